// File: rtl/fcs_pkg.sv
// constants and types shared by the flash command and status logic
// Summary of operation
// - command starts only with key 0x5A
// - wrong key discards write, starts nothing
// - status bit 0 is ready
// - locked-region program sets lock error
// - lock error sticky, cleared by status read
// - bad code or key sets program error
// - status bit 4 shows security bit
// - status bits 8,9 show general bits
// - status bits 16+ show region locks
// - region count is 16 or 8
// - reserved codes error, no-op code silent
// - interrupt sources gated by enable bits
package fcs_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h60;
    localparam logic [7:0] OFS_COMMAND = 8'h64;
    localparam logic [7:0] OFS_STATUS  = 8'h68;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h70;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h74;
    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BIT_READY    = 0;
    localparam int BIT_LOCKERR  = 2;
    localparam int BIT_PROGERR  = 3;
    localparam int BIT_SECURITY = 4;
    localparam int BIT_GPNV0    = 8;
    localparam int BIT_REGION0  = 16;
    localparam int KEY_LSB      = 24;
    localparam int PAGE_LSB     = 8;
    localparam logic [7:0] KEY_VALUE  = 8'h5a;
    localparam logic [31:0] MODE_MASK = 32'h0000_000d;
    ////////////////////////////////////////////////////////////////////////////////
    // command codes
    typedef enum logic [3:0] {
        FCS_NOP  = 4'h0,
        FCS_WP   = 4'h1,
        FCS_SLB  = 4'h2,
        FCS_WPL  = 4'h3,
        FCS_CLB  = 4'h4,
        FCS_EA   = 4'h8,
        FCS_SGPB = 4'hb,
        FCS_CGPB = 4'hd,
        FCS_SSB  = 4'hf
    } fcs_cmd_t;
    // operation time in clock cycles
    localparam int OP_CYCLES = 64;
    localparam int PAGE_BITS = 10;
endpackage : fcs_pkg

// File: rtl/fcs_op_if.sv
// interface carrying one accepted operation to the sequencer
`timescale 1ns/1ns
`default_nettype none
interface fcs_op_if;
    logic                           start;  // one-cycle start pulse
    fcs_pkg::fcs_cmd_t              cmd;    // command being started
    logic [fcs_pkg::PAGE_BITS-1:0]  page;   // page or bit number
    logic                           busy;   // operation running
    logic                           done;   // one-cycle completion pulse
    modport ctrl (output start, output cmd, output page, input busy, input done);
    modport seq  (input start, input cmd, input page, output busy, output done);
endinterface : fcs_op_if
`default_nettype wire

// File: rtl/fcs_sequencer.sv
// operation sequencer keeping non-volatile lock, general and security bits
`timescale 1ns/1ns
`default_nettype none
module fcs_sequencer #(
    parameter int REGIONS     = 16,
    parameter int PAGE_SHIFT  = 6
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // operation port
    fcs_op_if.seq                  op,
    // non-volatile state
    output logic [REGIONS-1:0]     locks,
    output logic [1:0]             gpnv,
    output logic                   security
);
    typedef enum logic [1:0] { SQ_IDLE, SQ_RUN, SQ_END } fcs_sq_t;
    fcs_sq_t                state;          // sequencer state
    logic [7:0]             count;          // running time counter
    fcs_pkg::fcs_cmd_t      cmd;            // latched command
    logic [fcs_pkg::PAGE_BITS-1:0] page;    // latched page
    logic [3:0]             region;         // region of latched page
    assign region   = 4'(page >> PAGE_SHIFT);
    assign op.busy  = (state != SQ_IDLE);
    assign op.done  = (state == SQ_END);
    ////////////////////////////////////////////////////////////////////////////////
    // sequence timing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= SQ_IDLE;
            count <= 8'h00;
            cmd   <= fcs_pkg::FCS_NOP;
            page  <= '0;
        end
        else
        begin
            case (state)
                SQ_IDLE:
                begin
                    if (op.start)
                    begin
                        state <= SQ_RUN;
                        count <= 8'(fcs_pkg::OP_CYCLES - 1);
                        cmd   <= op.cmd;
                        page  <= op.page;
                    end
                end
                SQ_RUN:
                begin
                    if (count == 8'h00)
                        state <= SQ_END;
                    else
                        count <= count - 8'h01;
                end
                default: state <= SQ_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // non-volatile bit updates at the end of an operation
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            locks    <= '0;
            gpnv     <= 2'h0;
            security <= 1'b0;
        end
        else if (state == SQ_END)
        begin
            case (cmd)
                fcs_pkg::FCS_SLB,
                fcs_pkg::FCS_WPL:  locks[region % REGIONS] <= 1'b1;
                fcs_pkg::FCS_CLB:  locks[region % REGIONS] <= 1'b0;
                fcs_pkg::FCS_SGPB: gpnv[page[0]] <= 1'b1;
                fcs_pkg::FCS_CGPB: gpnv[page[0]] <= 1'b0;
                fcs_pkg::FCS_SSB:  security <= 1'b1;
                default:           security <= security;
            endcase
        end
    end
endmodule : fcs_sequencer
`default_nettype wire

// File: rtl/fcs_top.sv
// flash command acceptance and status top with Avalon-MM slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fcs_top #(
    parameter int REGIONS    = 16,
    parameter int PAGE_SHIFT = 6
) (
    // clock and reset
    input  wire logic          CLK_SYS,
    input  wire logic          RSTN,
    // avalon-mm slave
    input  wire logic [7:0]    ADDRESS,
    input  wire logic          READ,
    input  wire logic          WRITE,
    input  wire logic [3:0]    BYTEENABLE,
    input  wire logic [31:0]   WRITEDATA,
    output logic [31:0]        READDATA,
    output logic               WAITREQUEST,
    // interrupt
    output logic               IRQ
);
    // region count check
    if (REGIONS != 16 && REGIONS != 8)
    begin : g_bad_regions
        $error("REGIONS must be 8 or 16");
    end
    fcs_op_if               op ();          // operation link
    logic [REGIONS-1:0]     locks;          // region lock state
    logic [1:0]             gpnv;           // general bits
    logic                   security;       // security bit
    logic [31:0]            mode;           // interrupt enables
    logic                   lock_err;       // sticky lock error
    logic                   prog_err;       // sticky program error
    logic [3:0]             irq_stat;       // sticky interrupt status
    logic                   acked;          // access answered this cycle
    logic [31:0]            status;         // assembled status word
    logic                   cmd_wr;         // command write accepted
    logic                   key_ok;         // key field correct
    logic                   code_ok;        // code is a defined command
    logic                   lock_hit;       // program targets locked region
    logic                   st_read;        // status read answered
    logic                   ready_rise;     // ready event
    logic                   ready_q;        // previous ready
    logic [3:0]             region;         // region of written page
    fcs_pkg::fcs_cmd_t      wcode;          // written command code
    ////////////////////////////////////////////////////////////////////////////////
    // command decode
    function automatic logic valid_code(input logic [3:0] c);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hb, 4'hd, 4'hf: valid_code = 1'b1;
            default: valid_code = 1'b0;
        endcase
    endfunction : valid_code
    function automatic logic is_program(input logic [3:0] c);
        is_program = (c == fcs_pkg::FCS_WP) || (c == fcs_pkg::FCS_WPL);
    endfunction : is_program
    assign wcode    = fcs_pkg::fcs_cmd_t'(WRITEDATA[3:0]);
    assign key_ok   = (WRITEDATA[fcs_pkg::KEY_LSB +: 8] == fcs_pkg::KEY_VALUE);
    assign code_ok  = valid_code(WRITEDATA[3:0]);
    assign region   = 4'(WRITEDATA[fcs_pkg::PAGE_LSB +: fcs_pkg::PAGE_BITS] >> PAGE_SHIFT);
    assign cmd_wr   = WRITE && acked && (ADDRESS == fcs_pkg::OFS_COMMAND) && BYTEENABLE[3];
    // erase-all with any lock also counts as a lock violation
    assign lock_hit = (is_program(WRITEDATA[3:0]) && locks[region % REGIONS])
                   || ((wcode == fcs_pkg::FCS_EA) && (|locks));
    assign st_read  = READ && acked && (ADDRESS == fcs_pkg::OFS_STATUS);
    ////////////////////////////////////////////////////////////////////////////////
    // one wait cycle per access, answer on second edge
    assign WAITREQUEST = (READ || WRITE) && !acked;
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            acked <= 1'b0;
        else
            acked <= (READ || WRITE) && !acked;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // operation start: right key, real command, ready, no lock hit
    always_comb
    begin
        op.start = cmd_wr && key_ok && code_ok && !op.busy && !lock_hit
                && (wcode != fcs_pkg::FCS_NOP);
        op.cmd   = wcode;
        op.page  = WRITEDATA[fcs_pkg::PAGE_LSB +: fcs_pkg::PAGE_BITS];
    end
    fcs_sequencer #(
        .REGIONS    (REGIONS),
        .PAGE_SHIFT (PAGE_SHIFT)
    ) u_seq (
        .clk      (CLK_SYS),
        .rst_n    (RSTN),
        .op       (op.seq),
        .locks    (locks),
        .gpnv     (gpnv),
        .security (security)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // sticky error flags, set beats read clear
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            lock_err <= 1'b0;
            prog_err <= 1'b0;
        end
        else
        begin
            if (cmd_wr && key_ok && code_ok && lock_hit)
                lock_err <= 1'b1;
            else if (st_read)
                lock_err <= 1'b0;
            if (cmd_wr && (!key_ok || !code_ok))
                prog_err <= 1'b1;
            else if (st_read)
                prog_err <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // status word assembly
    always_comb
    begin
        status = 32'h0000_0000;
        status[fcs_pkg::BIT_READY]    = !op.busy;
        status[fcs_pkg::BIT_LOCKERR]  = lock_err;
        status[fcs_pkg::BIT_PROGERR]  = prog_err;
        status[fcs_pkg::BIT_SECURITY] = security;
        status[fcs_pkg::BIT_GPNV0 +: 2] = gpnv;
        status[fcs_pkg::BIT_REGION0 +: REGIONS] = locks;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // mode register holding interrupt enables
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            mode <= 32'h0000_0000;
        else if (WRITE && acked && ADDRESS == fcs_pkg::OFS_MODE)
            mode <= WRITEDATA & fcs_pkg::MODE_MASK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // sticky interrupt status: ready, -, lock error, program error events
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            ready_q <= 1'b1;
        else
            ready_q <= !op.busy;
    end
    assign ready_rise = !op.busy && !ready_q;
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            irq_stat <= 4'h0;
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if ((i == fcs_pkg::BIT_READY && ready_rise)
                 || (i == fcs_pkg::BIT_LOCKERR && cmd_wr && key_ok && code_ok && lock_hit)
                 || (i == fcs_pkg::BIT_PROGERR && cmd_wr && (!key_ok || !code_ok)))
                    irq_stat[i] <= 1'b1;
                else if (WRITE && acked && ADDRESS == fcs_pkg::OFS_IRQ_CLR && WRITEDATA[i])
                    irq_stat[i] <= 1'b0;
            end
        end
    end
    assign IRQ = |(irq_stat & mode[3:0]);
    ////////////////////////////////////////////////////////////////////////////////
    // read data register
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            READDATA <= 32'h0000_0000;
        else if (READ && !acked)
        begin
            case (ADDRESS)
                fcs_pkg::OFS_MODE:   READDATA <= mode;
                fcs_pkg::OFS_STATUS: READDATA <= status;
                fcs_pkg::OFS_IRQ_ST: READDATA <= {28'h0000000, irq_stat};
                default:             READDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule : fcs_top
`default_nettype wire

// File: tb/fcs_top_sva.sv
// assertion checker for the flash command and status top
`timescale 1ns/1ns
`default_nettype none
module fcs_top_sva #(
    parameter int REGIONS    = 16,
    parameter int PAGE_SHIFT = 6
) (
    // clock, reset and bus
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic [7:0]  ADDRESS,
    input  wire logic        READ,
    input  wire logic        WRITE,
    input  wire logic [3:0]  BYTEENABLE,
    input  wire logic [31:0] WRITEDATA,
    input  wire logic [31:0] READDATA,
    input  wire logic        WAITREQUEST,
    input  wire logic        IRQ
);
    // completed status read, command write and mode write
    wire logic rd_st  = READ && !WAITREQUEST && ADDRESS == fcs_pkg::OFS_STATUS;
    wire logic wr_cmd = WRITE && !WAITREQUEST && ADDRESS == fcs_pkg::OFS_COMMAND
                        && BYTEENABLE[3];
    wire logic wr_md  = WRITE && !WAITREQUEST && ADDRESS == fcs_pkg::OFS_MODE;
    wire logic key_ok = WRITEDATA[31:24] == fcs_pkg::KEY_VALUE;
    wire logic code_ok = WRITEDATA[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8,
                                                4'hb, 4'hd, 4'hf};
    logic       perr_may;  // bad command since last status read
    logic       lerr_may;  // keyed command since last status read
    logic       en_any;    // some interrupt enable is set
    logic [7:0] since;     // cycles since last keyed command
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////////////////////
    // track which flags a read may legally show
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            perr_may <= 1'b0;
            lerr_may <= 1'b0;
            en_any   <= 1'b0;
            since    <= 8'hff;
        end
        else
        begin
            perr_may <= rd_st ? 1'b0 : perr_may | (wr_cmd & (!key_ok | !code_ok));
            lerr_may <= rd_st ? 1'b0 : lerr_may | (wr_cmd & key_ok);
            en_any   <= wr_md ? |(WRITEDATA[3:0] & 4'hd) : en_any;
            since    <= (wr_cmd && key_ok) ? 8'h00 : since + 8'(since != 8'hff);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_one_wait: assert property (($rose(READ) || $rose(WRITE)) |-> WAITREQUEST ##1 !WAITREQUEST)
        else $error("request not answered after one wait cycle");
    a_busy_keyed: assert property (rd_st && !READDATA[0] |-> since <= 8'h46)
        else $error("busy without a keyed command");
    a_ready_again: assert property (rd_st && since > 8'h46 |-> READDATA[0])
        else $error("ready not back in time");
    a_perr_set: assert property (rd_st && perr_may |-> READDATA[3])
        else $error("program error not reported");
    a_perr_quiet: assert property (rd_st && !perr_may |-> !READDATA[3])
        else $error("program error without cause");
    a_lerr_clear: assert property (rd_st && !lerr_may |-> !READDATA[2])
        else $error("lock error without cause");
    a_irq_gate: assert property (!en_any |-> !IRQ)
        else $error("interrupt with all enables clear");
    a_locks_width: assert property (rd_st && REGIONS == 8 |-> READDATA[31:24] == 8'h00)
        else $error("unimplemented lock bits set");
    a_spare_zero: assert property (rd_st |-> (READDATA & 32'h0000_fce2) == 32'h0)
        else $error("reserved status bits set");
endmodule : fcs_top_sva
bind fcs_top fcs_top_sva #(.REGIONS(REGIONS), .PAGE_SHIFT(PAGE_SHIFT)) u_sva (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .IRQ(IRQ));
`default_nettype wire

// File: tb/flash_command_status_tb_top.sv
// self-checking bench for the flash command and status top
`timescale 1ns/1ns
`default_nettype none
module flash_command_status_tb_top;
    logic        CLK_SYS, RSTN, READ, WRITE, WAITREQUEST, IRQ;
    logic [7:0]  ADDRESS;
    logic [3:0]  BYTEENABLE;
    logic [31:0] WRITEDATA, READDATA, rd;  // rd is the last read value
    logic [31:0] exp_q[$], msk_q[$];       // notes of expected reads
    int          n_fail, checks_done;
    fcs_top #(.REGIONS(8), .PAGE_SHIFT(6)) dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
        .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE),
        .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .IRQ(IRQ));
    // 25 MHz clock
    initial
    begin
        CLK_SYS = 1'b0;
        forever #20 CLK_SYS = ~CLK_SYS;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // watcher: each finished read takes the oldest note
    always @(posedge CLK_SYS)
    begin : mon
        logic [31:0] m;
        if (READ === 1'b1 && WAITREQUEST === 1'b0 && msk_q.size() > 0)
        begin
            m = msk_q.pop_front();
            if (m != 32'h0)
                chk(READDATA & m, exp_q.pop_front() & m);
            else
                void'(exp_q.pop_front());
        end
    end
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m = 32'h0);
        if (!wr)
        begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        ADDRESS   <= a;
        WRITEDATA <= wr ? d : 32'h0;
        WRITE     <= wr;
        READ      <= !wr;
        @(posedge CLK_SYS);
        while (WAITREQUEST !== 1'b0)
            @(posedge CLK_SYS);
        rd = READDATA;
        READ  <= 1'b0;
        WRITE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : bus
    // keyed command write
    task automatic cmd(input logic [3:0] c, input logic [9:0] p, input logic [7:0] k = 8'h5a);
        bus(1'b1, 8'h64, {k, 6'h00, p, 4'h0, c});
    endtask : cmd
    // poll status until ready
    task automatic wait_ready;
        do
            bus(1'b0, 8'h68, 32'h0);
        while (rd[0] !== 1'b1);
    endtask : wait_ready
    // check the interrupt line where settled
    task automatic chk_irq(input logic e);
        @(negedge CLK_SYS);
        chk({31'h0, IRQ}, {31'h0, e});
        @(posedge CLK_SYS);
    endtask : chk_irq
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        int         k;
        logic [2:0] r;
        logic [31:0] lk;
        RSTN = 1'b0; READ = 1'b0; WRITE = 1'b0; ADDRESS = 8'h00;
        BYTEENABLE = 4'hf; WRITEDATA = 32'h0; n_fail = 0; checks_done = 0;
        void'($urandom(32'h48f5ca0d));
        repeat (2) @(posedge CLK_SYS);
        RSTN <= 1'b1;
        @(posedge CLK_SYS);
        bus(1'b0, 8'h68, 32'h1, 32'hffff_ffff);
        bus(1'b0, 8'h6c, 32'h0, 32'hffff_ffff);
        $display("reset test done");
        repeat (4)
        begin
            k = (($urandom_range(254) + 8'h5b) % 256);    // never the good key
            cmd(4'h2, 10'h000, k[7:0]);
            bus(1'b0, 8'h68, 32'h9, 32'h0001_000d);
            bus(1'b0, 8'h68, 32'h1, 32'h0001_000d);
        end
        for (k = 0; k < 16; k++)
            if (!(k inside {1, 2, 3, 4, 8, 11, 13, 15}))
            begin
                cmd(k[3:0], 10'h000);
                bus(1'b0, 8'h68, (k == 0) ? 32'h1 : 32'h9, 32'hd);
            end
        $display("key and code test done");
        r  = 3'($urandom_range(7));
        lk = 32'h1 << (16 + r);
        cmd(4'h2, {1'b0, r, 6'h00});
        bus(1'b0, 8'h68, 32'h0, 32'h1);
        wait_ready;
        bus(1'b0, 8'h68, lk | 32'h1, 32'hffff_000d);
        cmd(4'h1, {1'b0, r, 6'h15});
        bus(1'b0, 8'h68, lk | 32'h5, 32'hffff_000d);
        bus(1'b0, 8'h68, lk | 32'h1, 32'hffff_000d);
        cmd(4'h8, 10'h000);
        bus(1'b0, 8'h68, lk | 32'h5, 32'hffff_000d);
        cmd(4'h4, {1'b0, r, 6'h00});
        wait_ready;
        bus(1'b0, 8'h68, 32'h1, 32'hffff_000d);
        $display("lock test done");
        cmd(4'hb, 10'h001);
        wait_ready;
        bus(1'b0, 8'h68, 32'h201, 32'h311);
        cmd(4'hb, 10'h000);
        wait_ready;
        bus(1'b0, 8'h68, 32'h301, 32'h311);
        cmd(4'hd, 10'h001);
        wait_ready;
        bus(1'b0, 8'h68, 32'h101, 32'h311);
        cmd(4'hf, 10'h000);
        wait_ready;
        bus(1'b0, 8'h68, 32'h111, 32'h311);
        $display("nonvolatile test done");
        bus(1'b1, 8'h60, 32'hffff_fff8);
        bus(1'b0, 8'h60, 32'h8, 32'hffff_ffff);
        cmd(4'h5, 10'h000);
        chk_irq(1'b1);
        bus(1'b0, 8'h70, 32'h8, 32'h8);
        bus(1'b1, 8'h74, 32'hd);
        chk_irq(1'b0);
        bus(1'b1, 8'h60, 32'h0);
        cmd(4'h5, 10'h000);
        chk_irq(1'b0);
        bus(1'b1, 8'h74, 32'hd);
        bus(1'b1, 8'h60, 32'h1);
        cmd(4'hb, 10'h000);
        chk_irq(1'b0);
        wait_ready;
        chk_irq(1'b1);
        $display("interrupt test done");
        give_verdict;
    end
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge CLK_SYS);
        n_fail++;
        give_verdict;
    end
endmodule : flash_command_status_tb_top
`default_nettype wire
